/* File: design/dfp_pkg.sv */
package dfp_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0]  REG_LOW        = 8'h00;
  localparam logic [7:0]  REG_HIGH       = 8'h01;
  localparam logic [7:0]  REG_RANGE      = 8'h02;
  localparam logic [15:0] REG_LOW_RST    = 16'h0000;
  localparam logic [9:0]  REG_HIGH_RST   = 10'h000;
  localparam logic        OE_CTRL_RST    = 1'b0;

  // ==========================================================
  // field layout
  localparam int          LOW_W          = 16;
  localparam int          HIGH_W         = 10;
  localparam int          WORD_W         = 26;
  localparam int          RANGE_W        = 4;
  localparam int          OE_BIT         = 10;
  localparam int          HIGH_PAD_W     = 5;
  localparam int          RANGE_PAD_W    = 12;

  // ==========================================================
  // offset word limits, two's complement
  localparam logic [25:0] OFFSET_ZERO    = 26'h0000000;
  localparam logic [25:0] OFFSET_POS_MAX = 26'h1FFFFFF;
  localparam logic [25:0] OFFSET_NEG_MAX = 26'h2000001;
  localparam logic [25:0] OFFSET_OUTSIDE = 26'h2000000;

  // ==========================================================
  // serial port
  localparam logic [6:0]  DEV_ADDR       = 7'h60;
  localparam logic        RW_WRITE       = 1'b1;
  localparam logic [3:0]  BIT_LAST       = 4'h7;
  localparam logic [3:0]  BIT_ACK        = 4'h8;
  localparam int          SYNC_W         = 8;
  localparam logic [1:0]  STRAP_TAKE     = 2'h2;

  // ==========================================================
  // timing
  localparam int          MCLK_PERIOD_PS = 4000;
  localparam int          SCL_MAX_KHZ    = 1000;
  localparam int          SCL_MIN_PER_PS = 1000000000 / SCL_MAX_KHZ;
  localparam int          SCL_MIN_CYC    = SCL_MIN_PER_PS / MCLK_PERIOD_PS;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_REG,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } dfp_state_e;

endpackage

/* File: design/dfp_sync.sv */
`timescale 1ns/1ps
module dfp_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ==========================================================
  // two stage synchroniser, first stage read only by second
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* File: design/dfp_ctrl.sv */
`timescale 1ns/1ps
// ==========================================================
module dfp_ctrl (
  input  wire logic                         mclk,
  input  wire logic                         resetn,
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe,
  input  wire logic                         oe_hw_mode,
  input  wire logic                         oe_pin,
  input  wire logic [dfp_pkg::RANGE_W-1:0]  factory_range,
  output logic      [dfp_pkg::WORD_W-1:0]   freq_word,
  output logic                              freq_update,
  output logic      [dfp_pkg::RANGE_W-1:0]  pull_range,
  output logic                              out_enable
);
  import dfp_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [SYNC_W-1:0] sync_q;
  wire               scl_s;
  wire               sda_s;
  wire               hw_mode_s;
  wire               oe_pin_s;
  wire [RANGE_W-1:0] strap_s;

  // idle bus is high, so scl and sda come out of reset high
  dfp_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL (8'hC0)
  ) u_sync (
    .clk    (mclk),
    .resetn (resetn),
    .d      ({scl_in, sda_in, oe_hw_mode, oe_pin, factory_range}),
    .q      (sync_q)
  );

  assign scl_s     = sync_q[7];
  assign sda_s     = sync_q[6];
  assign hw_mode_s = sync_q[5];
  assign oe_pin_s  = sync_q[4];
  assign strap_s   = sync_q[3:0];

  // ==========================================================
  // bus event detection
  logic scl_q_r;
  logic sda_q_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  // 250 MHz sampling leaves ample margin on a 1 MHz clock
  wire scl_rise  = scl_s & ~scl_q_r;
  wire scl_fall  = ~scl_s & scl_q_r;
  wire start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  wire stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // the fall that closes a start carries no bit, so it must not be counted
  logic seen_rise_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      seen_rise_r <= 1'b0;
    end else if (start_det) begin
      seen_rise_r <= 1'b0;
    end else if (scl_rise) begin
      seen_rise_r <= 1'b1;
    end
  end

  // ==========================================================
  // serial state
  dfp_state_e  st_r;
  logic [3:0]  cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic [7:0]  hold_r;
  logic        hi_r;
  logic        rd_hi_r;
  logic        oe_drv_r;

  logic [15:0] low_word_r;
  logic [9:0]  high_word_r;
  logic        oe_ctrl_r;
  logic [3:0]  range_r;
  logic [1:0]  strap_cnt_r;
  logic [25:0] freq_word_r;
  logic        update_r;

  wire [7:0]  ptr_nxt    = ptr_r + 8'h01;
  wire        byte_done  = scl_fall & (cnt_r == BIT_LAST);
  wire        ack_end    = scl_fall & (cnt_r == BIT_ACK);
  wire        addr_match = (shift_r[7:1] == DEV_ADDR);
  wire        wr_fire    = byte_done & (st_r == ST_WDATA) & ~hi_r;
  wire [15:0] wr_word    = {hold_r, shift_r};

  // ==========================================================
  // register read decode
  wire [15:0] rd_low   = low_word_r;
  wire [15:0] rd_high  = {{HIGH_PAD_W{1'b0}}, oe_ctrl_r, high_word_r};
  wire [15:0] rd_range = {{RANGE_PAD_W{1'b0}}, range_r};
  wire [15:0] rd_word  = (ptr_r == REG_LOW)   ? rd_low   :
                         (ptr_r == REG_HIGH)  ? rd_high  :
                         (ptr_r == REG_RANGE) ? rd_range : 16'h0000;
  wire [7:0]  rd_byte  = rd_hi_r ? rd_word[15:8] : rd_word[7:0];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_r     <= ST_IDLE;
      cnt_r    <= 4'h0;
      shift_r  <= 8'h00;
      tx_r     <= 8'hFF;
      ptr_r    <= 8'h00;
      hold_r   <= 8'h00;
      hi_r     <= 1'b1;
      rd_hi_r  <= 1'b1;
      oe_drv_r <= 1'b0;
    end else if (start_det) begin
      st_r     <= ST_DEV;
      cnt_r    <= 4'h0;
      oe_drv_r <= 1'b0;
    end else if (stop_det) begin
      st_r     <= ST_IDLE;
      cnt_r    <= 4'h0;
      oe_drv_r <= 1'b0;
    end else if (scl_rise && cnt_r < BIT_ACK) begin
      shift_r <= {shift_r[6:0], sda_s};
    end else if (byte_done) begin
      cnt_r <= BIT_ACK;
      case (st_r)
        ST_DEV: begin
          oe_drv_r <= addr_match;
          rd_hi_r  <= 1'b1;
          if (!addr_match) begin
            st_r <= ST_IGNORE;
          end else if (shift_r[0] == RW_WRITE) begin
            st_r <= ST_REG;
          end else begin
            st_r <= ST_RDATA;
          end
        end
        ST_REG: begin
          ptr_r    <= shift_r;
          hi_r     <= 1'b1;
          oe_drv_r <= 1'b1;
          st_r     <= ST_WDATA;
        end
        ST_WDATA: begin
          oe_drv_r <= 1'b1;
          hi_r     <= ~hi_r;
          if (hi_r) begin
            hold_r <= shift_r;
          end else begin
            ptr_r <= ptr_nxt;
          end
        end
        default: begin
          oe_drv_r <= 1'b0;
        end
      endcase
    end else if (ack_end) begin
      cnt_r <= 4'h0;
      if (st_r == ST_RDATA) begin
        // a master nack does not stop the slave, it keeps sending
        tx_r     <= rd_byte;
        oe_drv_r <= ~rd_byte[7];
        rd_hi_r  <= ~rd_hi_r;
        if (!rd_hi_r) begin
          ptr_r <= ptr_nxt;
        end
      end else begin
        oe_drv_r <= 1'b0;
      end
    end else if (scl_fall && seen_rise_r && cnt_r < BIT_LAST) begin
      cnt_r <= cnt_r + 4'h1;
      if (st_r == ST_RDATA) begin
        tx_r     <= {tx_r[6:0], 1'b1};
        oe_drv_r <= ~tx_r[6];
      end
    end
  end

  // ==========================================================
  // register file
  wire [25:0] commit_raw  = {wr_word[HIGH_W-1:0], low_word_r};
  // the one code below -full scale is pulled back inside the range
  wire [25:0] commit_word = (commit_raw == OFFSET_OUTSIDE) ? OFFSET_NEG_MAX
                                                           : commit_raw;
  wire        wr_low      = wr_fire & (ptr_r == REG_LOW);
  wire        wr_high     = wr_fire & (ptr_r == REG_HIGH);
  wire        wr_range    = wr_fire & (ptr_r == REG_RANGE);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      low_word_r  <= REG_LOW_RST;
      high_word_r <= REG_HIGH_RST;
      oe_ctrl_r   <= OE_CTRL_RST;
    end else begin
      if (wr_low) begin
        low_word_r <= wr_word;
      end
      if (wr_high) begin
        high_word_r <= wr_word[HIGH_W-1:0];
        oe_ctrl_r <= wr_word[OE_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      freq_word_r <= OFFSET_ZERO;
      update_r    <= 1'b0;
    end else begin
      update_r <= wr_high;
      if (wr_high) begin
        freq_word_r <= commit_word;
      end
    end
  end

  // strap settles through the synchroniser before it is taken
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      strap_cnt_r <= 2'h0;
      range_r     <= 4'h0;
    end else begin
      if (strap_cnt_r != 2'h3) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
      if (strap_cnt_r == STRAP_TAKE) begin
        range_r <= strap_s;
      end else if (wr_range) begin
        range_r <= wr_word[RANGE_W-1:0];
      end
    end
  end

  // ==========================================================
  // outputs
  assign sda_out     = 1'b0;
  assign sda_oe      = oe_drv_r;
  assign freq_word   = freq_word_r;
  assign freq_update = update_r;
  assign pull_range  = range_r;
  assign out_enable  = hw_mode_s ? oe_pin_s : oe_ctrl_r;

  // ==========================================================
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  start_to_addr_a: assert property (start_det |=> st_r == ST_DEV && cnt_r == 4'h0)
    else $error("start did not return to address phase");
  nack_mismatch_a: assert property (
    byte_done && st_r == ST_DEV && !addr_match |=> !sda_oe && st_r == ST_IGNORE)
    else $error("foreign address was acknowledged");
  high_commit_a: assert property (wr_high |=> freq_update ##0
    freq_word == (({$past(wr_word[9:0]), low_word_r} == OFFSET_OUTSIDE) ?
                   OFFSET_NEG_MAX : {$past(wr_word[9:0]), low_word_r}))
    else $error("upper word write did not commit the offset");
  low_no_commit_a: assert property (wr_low |=> $stable(freq_word) && !freq_update)
    else $error("low word write changed the offset");
  offset_range_a: assert property (freq_word != OFFSET_OUTSIDE)
    else $error("offset outside pull range");
  pin_mode_a: assert property (hw_mode_s |-> out_enable == oe_pin_s)
    else $error("software bit drove output in pin mode");
  pad_zero_a: assert property (ptr_r == REG_HIGH |-> rd_word[15:11] == 5'h00)
    else $error("unused bits read nonzero");
  ptr_wrap_a: assert property (wr_fire && ptr_r == 8'hFF |=> ptr_r == 8'h00)
    else $error("register address did not wrap");
  range_write_a: assert property (wr_range && strap_cnt_r == 2'h3 |=>
    pull_range == $past(wr_word[3:0]))
    else $error("range write lost");
  update_pulse_a: assert property (freq_update |=> !freq_update)
    else $error("update pulse longer than one cycle");
  data_ack_a: assert property (byte_done && st_r == ST_WDATA |=> sda_oe)
    else $error("data byte not acknowledged");
  strap_take_a: assert property (strap_cnt_r == STRAP_TAKE |=>
    pull_range == $past(strap_s))
    else $error("strap not loaded into range");
  range_pad_a: assert property (ptr_r == REG_RANGE |-> rd_word[15:4] == 12'h000)
    else $error("unused range bits read nonzero");
  bit_count_a: assert property (scl_fall && !seen_rise_r |=> $stable(cnt_r))
    else $error("fall without a bit was counted");

endmodule

/* File: tb/dfp_host.sv */
`timescale 1ns/1ps
// ==========================================================
// serial master model, open drain; scl stands high between frames
module dfp_host (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // sda moves only mid-low; 6 cycles a phase gives a 48 ns scl period
  task automatic bit_io(input logic b, output logic s);
    hw(3);
    sda_low <= ~b;
    hw(3);
    scl <= 1'b1;
    hw(3);
    s = sda;
    hw(3);
    scl <= 1'b0;
  endtask
  // also serves as repeated start when scl is low
  task automatic start();
    hw(3);
    sda_low <= 1'b0;
    hw(3);
    scl <= 1'b1;
    hw(6);
    sda_low <= 1'b1;
    hw(6);
    scl <= 1'b0;
  endtask
  task automatic stop();
    hw(3);
    sda_low <= 1'b1;
    hw(3);
    scl <= 1'b1;
    hw(6);
    sda_low <= 1'b0;
    hw(6);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // the device keeps sending after an ack; one byte clocked out with no
  // ack slot lets it release sda so that a stop can follow
  task automatic drain();
    logic s;
    for (int i = 0; i < 8; i++) bit_io(1'b1, s);
  endtask
  task automatic recv(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask
endmodule

/* File: tb/digital_freq_pull_control_test.sv */
`timescale 1ns/1ps
module digital_freq_pull_control_test;
  import dfp_pkg::*;
  localparam logic [3:0] STRAP = 4'hA;
  logic                 mclk = 1'b0;
  logic                 resetn;
  logic                 oe_hw_mode;
  logic                 oe_pin;
  logic [RANGE_W-1:0]   factory_range;
  logic                 scl, m_low, sda_out, sda_oe, freq_update, out_enable;
  logic [WORD_W-1:0]    freq_word;
  logic [RANGE_W-1:0]   pull_range;
  int                   n_fail = 0, cmp_count = 0, upd_count = 0;
  wire                  sda_w = ~(m_low | (sda_oe & ~sda_out));
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (freq_update === 1'b1) upd_count++;
  dfp_ctrl u_dut (
    .mclk          (mclk),
    .resetn        (resetn),
    .scl_in        (scl),
    .sda_in        (sda_w),
    .sda_out       (sda_out),
    .sda_oe        (sda_oe),
    .oe_hw_mode    (oe_hw_mode),
    .oe_pin        (oe_pin),
    .factory_range (factory_range),
    .freq_word     (freq_word),
    .freq_update   (freq_update),
    .pull_range    (pull_range),
    .out_enable    (out_enable)
  );
  dfp_host u_host (.mclk(mclk), .sda(sda_w), .scl(scl), .sda_low(m_low));
  // ==========================================================
  // helpers
  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [31:0] ws, input int n,
                    input logic [7:0] dev = 8'hC1);
    logic a;
    u_host.start();
    u_host.send(dev, a);
    chk("address ack", a, dev[7:1] == DEV_ADDR);
    u_host.send(ptr, a);
    for (int k = 0; k < 2 * n; k++) u_host.send(ws[31 - 8 * k -: 8], a);
    u_host.stop();
  endtask
  task automatic rchk(input logic [7:0] ptr, input logic [15:0] exp);
    logic a;
    logic [15:0] d;
    u_host.start();
    u_host.send(8'hC1, a);
    u_host.send(ptr, a);
    u_host.start();
    u_host.send(8'hC0, a);
    u_host.recv(d[15:8], 1'b1);
    u_host.recv(d[7:0], 1'b1);
    u_host.drain();
    u_host.stop();
    chk("read back", d, exp);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("freq_word", freq_word, 0);
    chk("out_enable", out_enable, 0);
    chk("pull_range", pull_range, STRAP);
    rchk(REG_LOW, 0);
    rchk(REG_HIGH, 0);
    rchk(REG_RANGE, STRAP);
  endtask
  // spacing between commits keeps updates under 38 kHz
  task automatic t_commit();
    wr(REG_LOW, 32'h5678_0000, 1);
    chk("freq_word", freq_word, 0);
    chk("updates", upd_count, 0);
    wr(REG_HIGH, 32'hFC12_0000, 1);
    chk("updates", upd_count, 1);
    chk("freq_word", freq_word, {10'h012, 16'h5678});
    chk("out_enable", out_enable, 1);
    rchk(REG_HIGH, 16'h0412);
    u_host.hw(6600);
  endtask
  task automatic t_burst();
    wr(REG_LOW, 32'hFFFF_01FF, 2);
    chk("freq_word", freq_word, OFFSET_POS_MAX);
    chk("out_enable", out_enable, 0);
    u_host.hw(6600);
    wr(8'hFF, 32'h1234_0000, 2);
    rchk(8'hFF, 0);
    rchk(REG_LOW, 0);
    wr(REG_HIGH, 32'h0600_0000, 1);
    chk("freq_word", freq_word, OFFSET_NEG_MAX);
    chk("updates", upd_count, 3);
    u_host.hw(6600);
  endtask
  task automatic t_range();
    logic [15:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 16'(i);
      wr(REG_RANGE, {16'hFFF0 | c, 16'h0000}, 1);
      chk("pull_range", pull_range, c);
      rchk(REG_RANGE, c);
    end
  endtask
  task automatic t_hw();
    oe_hw_mode <= 1'b1;
    u_host.hw(8);
    chk("out_enable", out_enable, 0);
    oe_pin <= 1'b1;
    u_host.hw(8);
    chk("out_enable", out_enable, 1);
    wr(REG_HIGH, 32'h0, 1);
    chk("out_enable", out_enable, 1);
    u_host.hw(6600);
  endtask
  task automatic t_nack();
    wr(REG_RANGE, 32'h0003_0000, 1, 8'hC3);
    chk("pull_range", pull_range, 15);
  endtask
  // a second reset mid-run, with a new strap value behind it
  task automatic t_reset_again();
    wr(REG_HIGH, 32'h0015_0000, 1);
    chk("freq_word", freq_word, {10'h015, 16'h0000});
    oe_hw_mode    <= 1'b0;
    factory_range <= 4'h5;
    resetn        <= 1'b0;
    u_host.hw(4);
    resetn <= 1'b1;
    u_host.hw(10);
    chk("freq_word", freq_word, 0);
    chk("out_enable", out_enable, 0);
    chk("pull_range", pull_range, 4'h5);
    rchk(REG_HIGH, 0);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    resetn        <= 1'b0;
    oe_hw_mode    <= 1'b0;
    oe_pin        <= 1'b0;
    factory_range <= STRAP;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    u_host.hw(10);
    t_reset();
    t_commit();
    t_burst();
    t_range();
    t_hw();
    t_nack();
    t_reset_again();
    wrap_up();
  end
  initial begin
    #400_000;
    n_fail++;
    wrap_up();
  end
endmodule
